// ---- cmsel_cfg.svh ----
// Constants for the CPU clock mode selector.
`ifndef CMSEL_CFG_SVH
`define CMSEL_CFG_SVH
`define CMSEL_STRAP_W 3
`define CMSEL_STRAP_X4 3'h7
`define CMSEL_STRAP_X3 3'h6
`define CMSEL_STRAP_X8 3'h5
`define CMSEL_STRAP_X5 3'h4
`define CMSEL_STRAP_DIRECT 3'h3
`define CMSEL_STRAP_X10 3'h2
`define CMSEL_STRAP_PRESCALE 3'h1
`define CMSEL_STRAP_X16 3'h0
`define CMSEL_STRAP_RESET 3'h7
`define CMSEL_FACTOR_W 5
`define CMSEL_FACTOR_1 5'h01
`define CMSEL_FACTOR_3 5'h03
`define CMSEL_FACTOR_4 5'h04
`define CMSEL_FACTOR_5 5'h05
`define CMSEL_FACTOR_8 5'h08
`define CMSEL_FACTOR_10 5'h0a
`define CMSEL_FACTOR_16 5'h10
`define CMSEL_MON_LIMIT 16
`define CMSEL_MON_W 5
`define CMSEL_MON_MIN 2
`endif

// ---- cmsel_pkg.sv ----
// Types shared by the CPU clock mode selector files.
package cmsel_pkg;
	typedef enum logic [1:0] {
		CMSEL_MODE_PLL = 2'b00,
		CMSEL_MODE_DIRECT = 2'b01,
		CMSEL_MODE_PRESCALE = 2'b10
	} cmsel_mode_type;

	typedef enum logic [1:0] {
		CMSEL_SRC_PLL = 2'b00,
		CMSEL_SRC_XTAL = 2'b01,
		CMSEL_SRC_DIV2 = 2'b10,
		CMSEL_SRC_FAILOVER = 2'b11
	} cmsel_src_type;

	typedef struct packed {
		cmsel_mode_type mode;
		logic [4:0] factor;
		logic pll_enable;
		logic pll_free_run;
		logic osc_amp_bypass;
	} cmsel_cfg_type;

	typedef struct packed {
		logic rise;
		logic fall;
	} cmsel_edge_type;
endpackage

// ---- cmsel_osc_monitor.sv ----
// Oscillator monitor: counts free-running PLL clocks between crystal edges.
`include "cmsel_cfg.svh"
module cmsel_osc_monitor #(
	parameter int LIMIT = `CMSEL_MON_LIMIT,
	parameter int CNT_W = `CMSEL_MON_W
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic enable_i,
	input wire logic pll_tick_i,
	input wire logic xtal_edge_i,
	output logic fail_o
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic fail;
	} cmsel_mon_state_type;

	cmsel_mon_state_type s_q;
	cmsel_mon_state_type s_d;

	if (LIMIT < `CMSEL_MON_MIN || LIMIT >= (1 << CNT_W)) begin : g_limit_check
		$error("cmsel_osc_monitor: LIMIT does not fit CNT_W");
	end

	always_comb begin
		s_d = s_q;
		if (!enable_i) begin
			s_d.cnt = '0;
		end else if (xtal_edge_i) begin
			s_d.cnt = '0;
		end else if (pll_tick_i && !s_q.fail) begin
			s_d.cnt = s_q.cnt + CNT_W'(1);
			if (s_d.cnt == CNT_W'(LIMIT)) begin
				s_d.fail = 1'b1;
			end
		end
		// The failure is sticky until the next reset.
		if (s_q.fail) begin
			s_d.fail = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign fail_o = s_q.fail;
endmodule // cmsel_osc_monitor

// ---- cmsel_top.sv ----
// CPU clock mode selector with strap decode, phase generation and monitor failover.
`include "cmsel_cfg.svh"
module cmsel_top #(
	parameter int STRAP_W = `CMSEL_STRAP_W,
	parameter int MON_LIMIT = `CMSEL_MON_LIMIT
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [STRAP_W-1:0] clock_mode_straps_i,
	input wire logic crystal_input_pin_i,
	input wire logic pll_clk_i,
	input wire logic osc_monitor_disable_i,
	output logic cpu_clk_o,
	output cmsel_pkg::cmsel_edge_type cpu_clock_phase_o,
	output cmsel_pkg::cmsel_cfg_type cfg_o,
	output cmsel_pkg::cmsel_src_type clk_src_o,
	output logic mode_valid_o,
	output logic osc_fail_irq_o
);
	typedef struct packed {
		logic latched;
		logic [STRAP_W-1:0] straps;
		cmsel_pkg::cmsel_cfg_type cfg;
		logic xtal_prev;
		logic pll_prev;
		logic div_clk;
		logic cpu_clk;
		cmsel_pkg::cmsel_edge_type phase;
		cmsel_pkg::cmsel_src_type src;
		logic irq;
	} cmsel_top_state_type;

	cmsel_top_state_type s_q;
	cmsel_top_state_type s_d;
	logic xtal_edge;
	logic xtal_rise;
	logic pll_tick;
	logic mon_enable;
	logic mon_fail;
	logic next_clk;

	if (STRAP_W != `CMSEL_STRAP_W) begin : g_strap_w_check
		$error("cmsel_top: STRAP_W must equal the strap count");
	end
	// The monitor counter has a fixed width and must be able to reach MON_LIMIT.
	if (MON_LIMIT < `CMSEL_MON_MIN || MON_LIMIT >= (1 << `CMSEL_MON_W)) begin : g_mon_limit_check
		$error("cmsel_top: MON_LIMIT does not fit the monitor counter");
	end

	// Only code 000 reaches the default branch, which selects the x16 multiplier.
	function automatic cmsel_pkg::cmsel_cfg_type decode(input logic [STRAP_W-1:0] straps);
		cmsel_pkg::cmsel_cfg_type c;
		c.mode = cmsel_pkg::CMSEL_MODE_PLL;
		c.factor = `CMSEL_FACTOR_4;
		c.pll_enable = 1'b1;
		c.pll_free_run = 1'b0;
		c.osc_amp_bypass = 1'b0;
		case (straps)
			`CMSEL_STRAP_X4: begin
				c.factor = `CMSEL_FACTOR_4;
			end
			`CMSEL_STRAP_X3: begin
				c.factor = `CMSEL_FACTOR_3;
			end
			`CMSEL_STRAP_X8: begin
				c.factor = `CMSEL_FACTOR_8;
			end
			`CMSEL_STRAP_X5: begin
				c.factor = `CMSEL_FACTOR_5;
			end
			`CMSEL_STRAP_DIRECT: begin
				c.mode = cmsel_pkg::CMSEL_MODE_DIRECT;
				c.factor = `CMSEL_FACTOR_1;
				c.pll_enable = 1'b0;
				c.osc_amp_bypass = 1'b1;
			end
			`CMSEL_STRAP_X10: begin
				c.factor = `CMSEL_FACTOR_10;
			end
			`CMSEL_STRAP_PRESCALE: begin
				c.mode = cmsel_pkg::CMSEL_MODE_PRESCALE;
				c.factor = `CMSEL_FACTOR_1;
				c.pll_enable = 1'b0;
			end
			default: begin
				c.factor = `CMSEL_FACTOR_16;
			end
		endcase
		return c;
	endfunction

	// Input clocks are oversampled, so they must stay well below half the system clock.
	// The previous levels reset low, so a high input at release looks like one extra edge.
	assign xtal_edge = crystal_input_pin_i != s_q.xtal_prev;
	assign xtal_rise = crystal_input_pin_i && !s_q.xtal_prev;
	assign pll_tick = pll_clk_i && !s_q.pll_prev;
	// The monitor only guards the modes that do not multiply through the PLL.
	assign mon_enable = s_q.latched && !osc_monitor_disable_i
		&& (s_q.cfg.mode != cmsel_pkg::CMSEL_MODE_PLL);

	cmsel_osc_monitor #(
		.LIMIT(MON_LIMIT),
		.CNT_W(`CMSEL_MON_W)
	) u_monitor (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.enable_i(mon_enable),
		.pll_tick_i(pll_tick),
		.xtal_edge_i(xtal_edge),
		.fail_o(mon_fail)
	);

	always_comb begin
		s_d = s_q;
		next_clk = s_q.cpu_clk;
		s_d.xtal_prev = crystal_input_pin_i;
		s_d.pll_prev = pll_clk_i;
		// Straps are taken once, at the first edge after reset release.
		if (!s_q.latched) begin
			s_d.latched = 1'b1;
			s_d.straps = clock_mode_straps_i;
			s_d.cfg = decode(clock_mode_straps_i);
		end
		// The PLL must run whenever the monitor watches the crystal or has taken over.
		if (s_q.latched && s_q.cfg.mode != cmsel_pkg::CMSEL_MODE_PLL) begin
			if (mon_fail) begin
				// After failover the free-running PLL is the CPU clock, so it stays on.
				s_d.cfg.pll_enable = 1'b1;
				s_d.cfg.pll_free_run = 1'b1;
			end else begin
				s_d.cfg.pll_free_run = !osc_monitor_disable_i;
				s_d.cfg.pll_enable = !osc_monitor_disable_i;
			end
		end
		// Divider toggles on each input rising edge, so each phase is one input period.
		if (xtal_rise) begin
			s_d.div_clk = !s_q.div_clk;
		end
		// Failover is sticky: the crystal never takes the CPU clock back before reset.
		if (!s_q.latched) begin
			s_d.src = cmsel_pkg::CMSEL_SRC_PLL;
		end else if (mon_fail) begin
			s_d.src = cmsel_pkg::CMSEL_SRC_FAILOVER;
		end else if (s_q.cfg.mode == cmsel_pkg::CMSEL_MODE_DIRECT) begin
			s_d.src = cmsel_pkg::CMSEL_SRC_XTAL;
		end else if (s_q.cfg.mode == cmsel_pkg::CMSEL_MODE_PRESCALE) begin
			s_d.src = cmsel_pkg::CMSEL_SRC_DIV2;
		end else begin
			s_d.src = cmsel_pkg::CMSEL_SRC_PLL;
		end
		case (s_q.src)
			cmsel_pkg::CMSEL_SRC_XTAL: begin
				next_clk = crystal_input_pin_i;
			end
			cmsel_pkg::CMSEL_SRC_DIV2: begin
				next_clk = s_d.div_clk;
			end
			cmsel_pkg::CMSEL_SRC_FAILOVER: begin
				next_clk = pll_clk_i;
			end
			default: begin
				next_clk = pll_clk_i;
			end
		endcase
		// Each strobe marks the edge that the registered CPU clock makes in this same cycle.
		s_d.cpu_clk = next_clk;
		s_d.phase.rise = next_clk && !s_q.cpu_clk;
		s_d.phase.fall = !next_clk && s_q.cpu_clk;
		// The request stays raised until reset, in step with the failover source.
		if (mon_fail) begin
			s_d.irq = 1'b1;
		end
	end

	// Reset state matches the default x4 PLL mode with the monitor idle.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q <= '{
				latched: 1'b0,
				straps: `CMSEL_STRAP_RESET,
				cfg: '{
					mode: cmsel_pkg::CMSEL_MODE_PLL,
					factor: `CMSEL_FACTOR_4,
					pll_enable: 1'b1,
					pll_free_run: 1'b0,
					osc_amp_bypass: 1'b0
				},
				xtal_prev: 1'b0,
				pll_prev: 1'b0,
				div_clk: 1'b0,
				cpu_clk: 1'b0,
				phase: '0,
				src: cmsel_pkg::CMSEL_SRC_PLL,
				irq: 1'b0
			};
		end else begin
			s_q <= s_d;
		end
	end

	assign cpu_clk_o = s_q.cpu_clk;
	assign cpu_clock_phase_o = s_q.phase;
	assign cfg_o = s_q.cfg;
	assign clk_src_o = s_q.src;
	assign mode_valid_o = s_q.latched;
	assign osc_fail_irq_o = s_q.irq;
endmodule // cmsel_top

// ---- cmsel_monitor.sv ----
// Port assertions for the CPU clock mode selector.
module cmsel_monitor #(
	parameter int STRAP_W = 3,
	parameter int MON_LIMIT = 16
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [STRAP_W-1:0] clock_mode_straps_i,
	input wire logic crystal_input_pin_i,
	input wire logic pll_clk_i,
	input wire logic osc_monitor_disable_i,
	input wire logic cpu_clk_o,
	input wire cmsel_pkg::cmsel_edge_type cpu_clock_phase_o,
	input wire cmsel_pkg::cmsel_cfg_type cfg_o,
	input wire cmsel_pkg::cmsel_src_type clk_src_o,
	input wire logic mode_valid_o,
	input wire logic osc_fail_irq_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [6:0] stall_q;
	logic [4:0] fac_t [8];
	assign fac_t = '{5'h10, 5'h01, 5'h0a, 5'h01, 5'h05, 5'h08, 5'h03, 5'h04};
	// Counts cycles for which the crystal level has stood still with osc_monitor_disable_i low, in any mode.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stall_q <= 7'h00;
		end else if (osc_monitor_disable_i || $changed(crystal_input_pin_i)) begin
			stall_q <= 7'h00;
		end else if (stall_q != 7'h7f) begin
			stall_q <= stall_q + 7'h01;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	strap_decode_a: assert property (
		$rose(mode_valid_o) |-> cfg_o.factor == fac_t[$past(clock_mode_straps_i)])
		else $error("factor does not match latched straps");
	mode_hold_a: assert property (
		mode_valid_o && $past(mode_valid_o) |-> $stable(cfg_o.mode) && $stable(cfg_o.factor))
		else $error("clock mode changed without reset");
	direct_cfg_a: assert property (
		mode_valid_o && cfg_o.mode == cmsel_pkg::CMSEL_MODE_DIRECT
		|-> cfg_o.osc_amp_bypass && cfg_o.factor == 5'h01)
		else $error("direct mode does not bypass amplifier");
	pll_gate_a: assert property (
		$past(mode_valid_o) && cfg_o.mode != cmsel_pkg::CMSEL_MODE_PLL && stall_q < 7'h14
		|-> cfg_o.pll_enable == (!$past(osc_monitor_disable_i) || osc_fail_irq_o)
		&& cfg_o.pll_free_run == (!$past(osc_monitor_disable_i) || osc_fail_irq_o))
		else $error("pll gating wrong for monitor state");
	direct_follow_a: assert property (
		clk_src_o == cmsel_pkg::CMSEL_SRC_XTAL && $past(clk_src_o) == cmsel_pkg::CMSEL_SRC_XTAL
		|-> cpu_clk_o == $past(crystal_input_pin_i))
		else $error("cpu clock does not follow crystal pin");
	prescale_a: assert property (
		$rose(crystal_input_pin_i) && clk_src_o == cmsel_pkg::CMSEL_SRC_DIV2
		&& $past(clk_src_o) == cmsel_pkg::CMSEL_SRC_DIV2
		|-> ##[1:3] $changed(cpu_clk_o))
		else $error("prescaler missed a crystal rise");
	edge_pulse_a: assert property (
		cpu_clock_phase_o == {$rose(cpu_clk_o), $fell(cpu_clk_o)})
		else $error("edge strobes do not match cpu clock");
	fail_hold_a: assert property (
		$past(osc_fail_irq_o) |-> osc_fail_irq_o && clk_src_o == cmsel_pkg::CMSEL_SRC_FAILOVER)
		else $error("failover released before reset");
	fail_follow_a: assert property (
		clk_src_o == cmsel_pkg::CMSEL_SRC_FAILOVER && $past(clk_src_o) == clk_src_o
		|-> cpu_clk_o == $past(pll_clk_i))
		else $error("failover clock does not follow pll");
	mon_detect_a: assert property (
		mode_valid_o && cfg_o.mode != cmsel_pkg::CMSEL_MODE_PLL
		&& stall_q == 7'(2 * MON_LIMIT + 8) |-> osc_fail_irq_o)
		else $error("stopped crystal not detected");
	mon_early_a: assert property (
		$rose(osc_fail_irq_o) |-> stall_q >= 7'(2 * MON_LIMIT - 4))
		else $error("monitor failed too early");
endmodule // cmsel_monitor
bind cmsel_top cmsel_monitor #(.STRAP_W(STRAP_W), .MON_LIMIT(MON_LIMIT)) mon (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .clock_mode_straps_i(clock_mode_straps_i),
	.crystal_input_pin_i(crystal_input_pin_i), .pll_clk_i(pll_clk_i),
	.osc_monitor_disable_i(osc_monitor_disable_i), .cpu_clk_o(cpu_clk_o),
	.cpu_clock_phase_o(cpu_clock_phase_o), .cfg_o(cfg_o), .clk_src_o(clk_src_o),
	.mode_valid_o(mode_valid_o), .osc_fail_irq_o(osc_fail_irq_o));

// ---- cmsel_xtal_model.sv ----
// Crystal and free-running PLL clock source model with settable crystal phases.
module cmsel_xtal_model (
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic [3:0] high_i,
	input wire logic [3:0] low_i,
	output logic xtal_o,
	output logic pll_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_q;
	initial begin
		xtal_o = 1'b0;
		pll_o = 1'b0;
		cnt_q = 4'h0;
	end
	// A failed crystal stands still at its last level while the PLL keeps running.
	always @(negedge clk_i) begin
		pll_o <= ~pll_o;
		cnt_q <= cnt_q + 4'h1;
		if (run_i && cnt_q + 4'h1 >= (xtal_o ? high_i : low_i)) begin
			xtal_o <= ~xtal_o;
			cnt_q <= 4'h0;
		end
	end
endmodule // cmsel_xtal_model

// ---- tb_cmsel_top.sv ----
// Self-checking bench for the CPU clock mode selector.
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
	$display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module tb_cmsel_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i, reset_n_i, dis, run, xtal, pll, cpu_clk, mvalid, irq;
	logic [2:0] straps;
	logic [3:0] hi, lo;
	cmsel_pkg::cmsel_edge_type phase;
	cmsel_pkg::cmsel_cfg_type cfg;
	cmsel_pkg::cmsel_src_type src;
	int failures, tests_run;
	logic [4:0] fac_t [8];
	cmsel_xtal_model xm (.clk_i(clk_i), .run_i(run), .high_i(hi), .low_i(lo), .xtal_o(xtal),
		.pll_o(pll));
	cmsel_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .clock_mode_straps_i(straps),
		.crystal_input_pin_i(xtal), .pll_clk_i(pll), .osc_monitor_disable_i(dis),
		.cpu_clk_o(cpu_clk), .cpu_clock_phase_o(phase), .cfg_o(cfg), .clk_src_o(src),
		.mode_valid_o(mvalid), .osc_fail_irq_o(irq));
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Straps are inverted after the latch so that a late sample shows up.
	task automatic boot(input logic [2:0] s, input logic [3:0] h, input logic [3:0] l);
		reset_n_i = 1'b0;
		straps = s;
		hi = h;
		lo = l;
		run = 1'b1;
		repeat (20) @(negedge clk_i);
		reset_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		straps = ~s;
		repeat (4) @(negedge clk_i);
	endtask
	task automatic wait_cpu(input logic v, output int n);
		n = 0;
		while (cpu_clk !== v) begin
			@(negedge clk_i);
			n++;
			if (n > 60) begin
				failures++;
				close_out();
			end
		end
	endtask
	task automatic phases(input int h, input int l);
		int n;
		wait_cpu(1'b0, n);
		wait_cpu(1'b1, n);
		wait_cpu(1'b0, n);
		`CHK(n, h)
		wait_cpu(1'b1, n);
		`CHK(n, l)
	endtask
	task automatic t_straps();
		cmsel_pkg::cmsel_mode_type m;
		for (int s = 0; s < 8; s++) begin
			boot(3'(s), 4'h2, 4'h2);
			m = (s == 3) ? cmsel_pkg::CMSEL_MODE_DIRECT : cmsel_pkg::CMSEL_MODE_PLL;
			m = (s == 1) ? cmsel_pkg::CMSEL_MODE_PRESCALE : m;
			`CHK(cfg.factor, fac_t[s])
			`CHK(cfg.mode, m)
		end
		phases(1, 1);
		$display("test straps done");
	endtask
	task automatic t_modes();
		boot(3'h3, 4'h2, 4'h4);
		`CHK(src, cmsel_pkg::CMSEL_SRC_XTAL)
		`CHK(cfg.pll_free_run, 1'b1)
		phases(2, 4);
		dis = 1'b1;
		repeat (3) @(negedge clk_i);
		`CHK(cfg.pll_enable, 1'b0)
		dis = 1'b0;
		boot(3'h1, 4'h1, 4'h3);
		`CHK(src, cmsel_pkg::CMSEL_SRC_DIV2)
		phases(4, 4);
		$display("test modes done");
	endtask
	task automatic t_fail();
		int n;
		boot(3'h3, 4'h2, 4'h2);
		dis = 1'b1;
		run = 1'b0;
		repeat (60) @(negedge clk_i);
		`CHK(irq, 1'b0)
		dis = 1'b0;
		n = 0;
		while (irq !== 1'b1 && n < 50) begin
			@(negedge clk_i);
			n++;
		end
		if (irq !== 1'b1) begin
			failures++;
			close_out();
		end
		`CHK(n > 25, 1'b1)
		`CHK(n < 40, 1'b1)
		run = 1'b1;
		repeat (20) @(negedge clk_i);
		`CHK(src, cmsel_pkg::CMSEL_SRC_FAILOVER)
		`CHK(irq, 1'b1)
		`CHK(cfg.pll_free_run, 1'b1)
		boot(3'h3, 4'h2, 4'h2);
		`CHK(irq, 1'b0)
		$display("test failover done");
	endtask
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		fac_t = '{5'h10, 5'h01, 5'h0a, 5'h01, 5'h05, 5'h08, 5'h03, 5'h04};
		reset_n_i = 1'b0;
		dis = 1'b0;
		run = 1'b1;
		hi = 4'h2;
		lo = 4'h2;
		straps = 3'h7;
		t_straps();
		t_modes();
		t_fail();
		close_out();
	end
endmodule // tb_cmsel_top
